// File: dpscd_consts.vh
/*
 * Constants of the dual potentiometer serial command decoder: frame codes,
 * instruction codes, register geometry, reset values and the write-cycle time.
 * Assumes inclusion by the decoder design file only; definitions only.
 */
// Operation
// - Wiper write: select, instruction, eight data bits
// - Stored-setting read shifts eight bits MSB first
// - Stored-setting write takes byte, high-voltage cycle
// - Status byte: bit0 write pending, others zero
// - Global copy stored bank into all wipers
// - Global copy all wipers into stored bank
// - Copy one wiper into its stored setting
// - Load one wiper from stored setting
// - Step mode: step bits until select rises
// - Non-volatile cycle starts after select rises
// - Wiper read shifts eight bits out
// - Write pending high while cycle runs
// - Input high steps up, low steps down
// - Non-volatile change completes within 5 ms
`ifndef DPSCD_CONSTS_VH
`define DPSCD_CONSTS_VH

// Device-select byte upper six bits (0101 00)
`define DPSCD_DEVSEL_FIXED   6'h14
// Instruction opcodes, upper nibble of the instruction byte
`define DPSCD_OP_RD_WIPER    4'h9
`define DPSCD_OP_WR_WIPER    4'hA
`define DPSCD_OP_RD_STORED   4'hB
`define DPSCD_OP_WR_STORED   4'hC
`define DPSCD_OP_LOAD_WIPER  4'hD
`define DPSCD_OP_SAVE_WIPER  4'hE
`define DPSCD_OP_GLOBAL_LOAD 4'h1
`define DPSCD_OP_GLOBAL_SAVE 4'h8
`define DPSCD_OP_STEP        4'h2
// Full status instruction byte
`define DPSCD_STATUS_INSTR   8'h51
// Wiper limits, wiper reset value and stored-setting reset value
`define DPSCD_WIPER_MAX      8'hFF
`define DPSCD_WIPER_MIN      8'h00
`define DPSCD_WIPER_RST      8'h80
`define DPSCD_STORED_RST     8'h00
// Non-volatile write time in microseconds and clock rate in MHz
`define DPSCD_NV_WRITE_US    5000
`define DPSCD_CLK_MHZ        200
`define DPSCD_NV_WRITE_CYC   (`DPSCD_NV_WRITE_US * `DPSCD_CLK_MHZ)

`endif

// File: dpscd_sync2.v
/*
 * Two-flop level synchroniser for a single pin.
 * Assumes the input is asynchronous to i_sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module dpscd_sync2 #(
    parameter [0:0] RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire i_sys_clk,
    input  wire i_srst,
    // Pin in, synchronised level out
    input  wire i_async,
    output wire o_sync
);
    reg meta_r;
    reg sync_r;

    // First flop feeds only the second
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule
`default_nettype wire

// File: dpscd_decoder.v
/*
 * Serial command decoder of a dual 256-tap digital potentiometer: device
 * select, instruction, data or step bits; two wipers, eight stored settings,
 * write-pending flag and a timed non-volatile write cycle after select rises.
 * Assumes SPI mode 0 from the master, serial clock well below i_sys_clk/8,
 * and that the three serial input pins are asynchronous to i_sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpscd_consts.vh"
module dpscd_decoder #(
    parameter        NV_WRITE_CYC = `DPSCD_NV_WRITE_CYC,
    parameter [1:0]  DEV_ADDR     = 2'b00
) (
    // Clock and reset
    input  wire       i_sys_clk,
    input  wire       i_srst,
    // Serial pins
    input  wire       i_cs_n,
    input  wire       i_sck,
    input  wire       i_si,
    output reg        o_so,
    output reg        o_so_oe,
    // Wiper positions and status
    output reg  [7:0] o_wiper0,
    output reg  [7:0] o_wiper1,
    output reg        o_write_pending_flag
);
    localparam ST_DEV   = 4'b0001;
    localparam ST_INSTR = 4'b0010;
    localparam ST_DATA  = 4'b0100;
    localparam ST_IGN   = 4'b1000;

    wire       cs_n_s;
    wire       sck_s;
    wire       si_s;
    reg        sck_d_r;
    reg        cs_n_d_r;
    reg  [3:0] state_r;
    reg  [2:0] bit_cnt_r;
    reg  [7:0] shift_r;
    reg  [7:0] instr_r;
    reg  [7:0] tx_r;
    reg  [7:0] stored_r [0:7];
    reg        nv_op_r;      // 0: single save, 1: global save
    reg        nv_arm_r;
    reg  [7:0] nv_data_r;
    reg  [2:0] nv_idx_r;
    reg  [31:0] nv_cnt_r;
    reg  [7:0] sel_wiper;
    wire       rise;
    wire       fall;
    wire       cs_rise;
    wire [7:0] rx_byte;
    wire [3:0] op;
    wire [2:0] idx;
    integer    k;

    dpscd_sync2 #(.RST_VAL(1'b1)) u_cs  (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_async(i_cs_n), .o_sync(cs_n_s));
    dpscd_sync2 #(.RST_VAL(1'b0)) u_sck (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_async(i_sck),  .o_sync(sck_s));
    dpscd_sync2 #(.RST_VAL(1'b0)) u_si  (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_async(i_si),   .o_sync(si_s));

    // Edge detection on synchronised levels
    assign rise    = sck_s & ~sck_d_r & ~cs_n_s;
    assign fall    = ~sck_s & sck_d_r & ~cs_n_s;
    assign cs_rise = cs_n_s & ~cs_n_d_r;
    assign rx_byte = {shift_r[6:0], si_s};
    assign op      = instr_r[7:4];
    // Stored index: pot select high bit, bank select two low bits
    assign idx     = {instr_r[0], instr_r[3:2]};

    // Wiper chosen by pot select
    always @* begin
        sel_wiper = instr_r[0] ? o_wiper1 : o_wiper0;
    end

    // Frame decoder, wipers and stored settings
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            sck_d_r              <= 1'b0;
            cs_n_d_r             <= 1'b1;
            state_r              <= ST_DEV;
            bit_cnt_r            <= 3'h0;
            shift_r              <= 8'h00;
            instr_r              <= 8'h00;
            tx_r                 <= 8'h00;
            o_so                 <= 1'b0;
            o_so_oe              <= 1'b0;
            o_wiper0             <= `DPSCD_WIPER_RST;
            o_wiper1             <= `DPSCD_WIPER_RST;
            o_write_pending_flag <= 1'b0;
            nv_op_r              <= 1'b0;
            nv_arm_r             <= 1'b0;
            nv_data_r            <= 8'h00;
            nv_idx_r             <= 3'h0;
            nv_cnt_r             <= 32'h0;
            for (k = 0; k < 8; k = k + 1) begin
                stored_r[k] <= `DPSCD_STORED_RST;
            end
        end else begin
            sck_d_r  <= sck_s;
            cs_n_d_r <= cs_n_s;
            // Non-volatile cycle timer; flag high while it runs
            if (o_write_pending_flag) begin
                if (nv_cnt_r == 32'h0) begin
                    o_write_pending_flag <= 1'b0;
                    if (nv_op_r) begin
                        stored_r[{1'b0, nv_idx_r[1:0]}] <= o_wiper0;
                        stored_r[{1'b1, nv_idx_r[1:0]}] <= o_wiper1;
                    end else begin
                        stored_r[nv_idx_r] <= nv_data_r;
                    end
                end else begin
                    nv_cnt_r <= nv_cnt_r - 32'h1;
                end
            end
            if (cs_n_s) begin
                state_r   <= ST_DEV;
                bit_cnt_r <= 3'h0;
                o_so_oe   <= 1'b0;
            end
            // Armed cycle starts only once select has risen
            if (cs_rise && nv_arm_r) begin
                nv_arm_r             <= 1'b0;
                o_write_pending_flag <= 1'b1;
                nv_cnt_r             <= NV_WRITE_CYC - 1;
            end
            // Output shift on falling edge, MSB first
            if (fall && state_r == ST_DATA) begin
                o_so <= tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
            end
            if (rise) begin
                shift_r   <= rx_byte;
                bit_cnt_r <= bit_cnt_r + 3'h1;
                case (state_r)
                    ST_DEV: begin
                        if (bit_cnt_r == 3'h7) begin
                            state_r <= (rx_byte == {`DPSCD_DEVSEL_FIXED, DEV_ADDR}) ? ST_INSTR : ST_IGN;
                        end
                    end
                    ST_INSTR: begin
                        if (bit_cnt_r == 3'h7) begin
                            instr_r <= rx_byte;
                            state_r <= ST_DATA;
                            o_so_oe <= 1'b0;
                            tx_r    <= 8'h00;
                            case (rx_byte[7:4])
                                `DPSCD_OP_RD_WIPER: begin
                                    tx_r    <= rx_byte[0] ? o_wiper1 : o_wiper0;
                                    o_so_oe <= 1'b1;
                                end
                                `DPSCD_OP_RD_STORED: begin
                                    tx_r    <= stored_r[{rx_byte[0], rx_byte[3:2]}];
                                    o_so_oe <= 1'b1;
                                end
                                `DPSCD_OP_LOAD_WIPER: begin
                                    if (rx_byte[0]) o_wiper1 <= stored_r[{1'b1, rx_byte[3:2]}];
                                    else o_wiper0 <= stored_r[{1'b0, rx_byte[3:2]}];
                                    state_r <= ST_IGN;
                                end
                                `DPSCD_OP_GLOBAL_LOAD: begin
                                    o_wiper0 <= stored_r[{1'b0, rx_byte[3:2]}];
                                    o_wiper1 <= stored_r[{1'b1, rx_byte[3:2]}];
                                    state_r  <= ST_IGN;
                                end
                                `DPSCD_OP_SAVE_WIPER: begin
                                    nv_arm_r  <= ~o_write_pending_flag;
                                    nv_op_r   <= 1'b0;
                                    nv_idx_r  <= {rx_byte[0], rx_byte[3:2]};
                                    nv_data_r <= rx_byte[0] ? o_wiper1 : o_wiper0;
                                    state_r   <= ST_IGN;
                                end
                                `DPSCD_OP_GLOBAL_SAVE: begin
                                    nv_arm_r <= ~o_write_pending_flag;
                                    nv_op_r  <= 1'b1;
                                    nv_idx_r <= {1'b0, rx_byte[3:2]};
                                    state_r  <= ST_IGN;
                                end
                                default: begin
                                    if (rx_byte == `DPSCD_STATUS_INSTR) begin
                                        tx_r    <= {7'h00, o_write_pending_flag};
                                        o_so_oe <= 1'b1;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_DATA: begin
                        if (op == `DPSCD_OP_STEP) begin
                            // One step per clock; saturate at the ends
                            if (si_s && sel_wiper != `DPSCD_WIPER_MAX) begin
                                if (instr_r[0]) o_wiper1 <= o_wiper1 + 8'h01;
                                else o_wiper0 <= o_wiper0 + 8'h01;
                            end else if (!si_s && sel_wiper != `DPSCD_WIPER_MIN) begin
                                if (instr_r[0]) o_wiper1 <= o_wiper1 - 8'h01;
                                else o_wiper0 <= o_wiper0 - 8'h01;
                            end
                        end else if (bit_cnt_r == 3'h7) begin
                            state_r <= ST_IGN;
                            if (op == `DPSCD_OP_WR_WIPER) begin
                                if (instr_r[0]) o_wiper1 <= rx_byte;
                                else o_wiper0 <= rx_byte;
                            end else if (op == `DPSCD_OP_WR_STORED) begin
                                nv_arm_r  <= ~o_write_pending_flag;
                                nv_op_r   <= 1'b0;
                                nv_idx_r  <= idx;
                                nv_data_r <= rx_byte;
                            end
                        end
                    end
                    ST_IGN: begin
                        state_r <= ST_IGN;
                    end
                    default: begin
                        state_r <= ST_DEV;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: dpscd_assertions.sv
/* Port checker for dpscd_decoder, bound to every instance of it.
   Assumes synchronous active-high reset and a serial clock far slower than i_sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module dpscd_chk #(parameter NV_WRITE_CYC = 50) (
    // Clock and reset
    input wire       i_sys_clk,
    input wire       i_srst,
    // Serial pins
    input wire       i_cs_n,
    input wire       i_sck,
    input wire       i_si,
    input wire       o_so,
    input wire       o_so_oe,
    // Wipers and status
    input wire [7:0] o_wiper0,
    input wire [7:0] o_wiper1,
    input wire       o_write_pending_flag
);
    int cnt_r;
    // Length of the current write-pending run
    always @(posedge i_sys_clk) cnt_r <= (i_srst || !o_write_pending_flag) ? 0 : cnt_r + 1;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    a_reset_values: assert property (disable iff (1'b0) i_srst |=> o_wiper0 == 8'h80 && o_wiper1 == 8'h80
        && !o_write_pending_flag && !o_so_oe) else $error("reset values wrong");
    a_flag_after_cs: assert property ($rose(o_write_pending_flag) |-> i_cs_n) else $error("flag inside frame");
    a_flag_hold: assert property ($rose(o_write_pending_flag) |-> o_write_pending_flag[*8]) else $error("flag short");
    a_flag_width: assert property ($fell(o_write_pending_flag) |->
        cnt_r >= NV_WRITE_CYC - 1 && cnt_r <= NV_WRITE_CYC + 1) else $error("cycle length wrong");
    a_oe_start: assert property ($rose(o_so_oe) |-> !i_cs_n) else $error("drive outside frame");
    a_oe_idle: assert property (i_cs_n[*6] |-> !o_so_oe) else $error("drive while idle");
    a_so_steady: assert property (i_sck[*6] |-> $stable(o_so)) else $error("so moved in sck high");
    a_wiper_idle: assert property (i_cs_n[*8] |-> $stable(o_wiper0) && $stable(o_wiper1))
        else $error("wiper moved while idle");
    c_nv_cycle: cover property ($fell(o_write_pending_flag));
    c_read: cover property ($rose(o_so_oe));
    c_wiper: cover property ($changed(o_wiper1));
endmodule
bind dpscd_decoder dpscd_chk #(.NV_WRITE_CYC(NV_WRITE_CYC)) u_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe), .o_wiper0(o_wiper0),
    .o_wiper1(o_wiper1), .o_write_pending_flag(o_write_pending_flag));
`default_nettype wire

// File: dpscd_spi_master.sv
/* Serial master model: mode 0, sck idles low, one command per select-low period.
   Assumes i_sys_clk at 200 MHz; pins change at its falling edge. */
`timescale 1ns/1ps
`default_nettype none
module dpscd_spi_master (
    // Clock and device data out
    input  wire logic i_sys_clk,
    input  wire logic i_so,
    // Serial pins
    output var  logic o_cs_n,
    output var  logic o_sck,
    output var  logic o_si
);
    int half = 16; // Sys cycles per sck half period
    // Idle pins at time zero
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
    end
    // Whole frame, MSB first; last eight sampled bits are returned
    task automatic frame(input int n, input logic [23:0] d, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge i_sys_clk);
        o_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_si = d[i];
            repeat (half) @(negedge i_sys_clk);
            o_sck = 1'b1;
            rd = {rd[6:0], i_so};
            repeat (half) @(negedge i_sys_clk);
            o_sck = 1'b0;
        end
        repeat (half) @(negedge i_sys_clk);
        o_cs_n = 1'b1;
        o_si = ~o_si; // Released line shows no stale value
        repeat (16) @(negedge i_sys_clk);
    endtask
endmodule
`default_nettype wire

// File: dpscd_tb.sv
/* Self-checking bench of dpscd_decoder driven through the serial master model.
   Assumes a shortened non-volatile cycle of 2000 clocks. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam NV = 2000;
    logic       clk, srst, cs_n, sck, si, so, so_oe, flag, p;
    logic [7:0] w0, w1, rd, v, s, e, dev;
    logic [7:0] wexp [2];
    logic [7:0] sexp [8];
    logic [1:0] b;
    int         n_fail, check_count;
    dpscd_decoder #(.NV_WRITE_CYC(NV), .DEV_ADDR(2'b00)) dut (.i_sys_clk(clk), .i_srst(srst), .i_cs_n(cs_n),
        .i_sck(sck), .i_si(si), .o_so(so), .o_so_oe(so_oe), .o_wiper0(w0), .o_wiper1(w1), .o_write_pending_flag(flag));
    dpscd_spi_master m (.i_sys_clk(clk), .i_so(so), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function logic [7:0] mk(input logic [3:0] op, input logic [1:0] bk, input logic pt);
        mk = {op, bk, 1'b0, pt};
    endfunction
    function logic [7:0] stepw(input logic [7:0] w, input logic up);
        stepw = up ? ((w == 8'hFF) ? w : w + 8'h01) : ((w == 8'h00) ? w : w - 8'h01);
    endfunction
    // Device byte, instruction, then k trailing bits
    task cmd(input logic [7:0] ins, input logic [7:0] dat, input int k);
        m.frame(16 + k, ({8'h00, dev, ins} << k) | {16'h0000, dat}, rd);
    endtask
    task chkw;
        chk(w0, wexp[0]);
        chk(w1, wexp[1]);
    endtask
    // Bounded wait for the non-volatile cycle to end
    task wait_nv;
        chk({7'h00, flag}, 8'h01);
        for (int i = 0; flag !== 1'b0; i++) begin
            if (i > 2 * NV) begin
                n_fail++;
                final_report;
            end
            @(negedge clk);
        end
    endtask
    initial begin
        srst = 1'b1;
        dev = 8'h50;
        void'($urandom(32'h21DA));
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        wexp = '{8'h80, 8'h80};
        chkw;
        chk({7'h00, flag}, 8'h00);
        $display("reset test done");
        for (int j = 0; j < 2; j++) begin
            p = j[0];
            wexp[p] = 8'($urandom);
            cmd(mk(4'hA, 2'b00, p), wexp[p], 8);
            chkw;
            cmd(mk(4'h9, 2'b00, p), 8'h00, 8);
            chk(rd, wexp[p]);
            chk({7'h00, so_oe}, 8'h00);
            b = 2'($urandom);
            v = 8'($urandom);
            cmd(mk(4'hC, b, p), v, 8);
            sexp[{p, b}] = v;
            cmd(8'h51, 8'h00, 8);
            chk(rd, 8'h01);
            wait_nv;
            cmd(8'h51, 8'h00, 8);
            chk(rd, 8'h00);
            cmd(mk(4'hB, b, p), 8'h00, 8);
            chk(rd, sexp[{p, b}]);
            cmd(mk(4'hA, 2'b00, p), 8'($urandom), 8);
            cmd(mk(4'hD, b, p), 8'h00, 0);
            wexp[p] = sexp[{p, b}];
            chkw;
            chk({7'h00, flag}, 8'h00);
            b = b + 2'd1;
            cmd(mk(4'hE, b, p), 8'h00, 0);
            wait_nv;
            cmd(mk(4'hB, b, p), 8'h00, 8);
            chk(rd, wexp[p]);
        end
        $display("stored register test done");
        b = 2'($urandom);
        cmd(mk(4'h8, b, 1'b0), 8'h00, 0);
        wait_nv;
        sexp[{1'b0, b}] = wexp[0];
        sexp[{1'b1, b}] = wexp[1];
        cmd(mk(4'hA, 2'b00, 1'b0), 8'($urandom), 8);
        cmd(mk(4'hA, 2'b00, 1'b1), 8'($urandom), 8);
        cmd(mk(4'h1, b, 1'b0), 8'h00, 0);
        chkw;
        $display("global copy test done");
        for (int t = 0; t < 3; t++) begin
            v = (t == 0) ? 8'hFE : (t == 1) ? 8'h01 : 8'($urandom);
            s = (t == 0) ? 8'h0E : (t == 1) ? 8'h00 : 8'($urandom);
            m.half = (t == 1) ? 40 : 16;
            cmd(mk(4'hA, 2'b00, 1'b1), v, 8);
            cmd(mk(4'h2, 2'b00, 1'b1), s, (t == 2) ? 8 : 4);
            e = v;
            for (int i = ((t == 2) ? 7 : 3); i >= 0; i--)
                e = stepw(e, s[i]);
            wexp[1] = e;
            chkw;
        end
        m.half = 16;
        $display("step test done");
        dev = 8'h51;
        cmd(mk(4'hA, 2'b00, 1'b0), ~wexp[0], 8);
        dev = 8'h50;
        chkw;
        $display("device select test done");
        final_report;
    end
endmodule
`default_nettype wire
